/* File: shared/spi_map.vh */
// Purpose: Constants for the SPI slave/master unit with enable pin modes
// Assumes: Included by the controller design file by bare name
// Notes: Definitions only
`ifndef SPI_MAP_VH
`define SPI_MAP_VH

// ----------------------------------------
// Framing
// ----------------------------------------
`define SPI_BYTE_BITS 8
`define SPI_LAST_BIT 3'h7
`define SPI_LAST_HALF 4'hf
`define SPI_DUMMY_BYTE 8'h00

// ----------------------------------------
// Enable pin level that means active
// ----------------------------------------
`define SPI_ENABLE_ACTIVE 1'b0

// ----------------------------------------
// Timing: master half period in clk cycles
// ----------------------------------------
`define SPI_HALF_PERIOD 8'h04

// ----------------------------------------
// Buffers
// ----------------------------------------
`define SPI_BUF_DEPTH 2
`define SPI_BUF_PTR_W 1

// ----------------------------------------
// Master states
// ----------------------------------------
`define SPI_M_IDLE 2'h0
`define SPI_M_RUN 2'h1
`define SPI_M_GAP 2'h2

`endif

/* File: hdl/spi_fifo.v */
// Purpose: Small valid/ready FIFO used for transmit and receive words
// Assumes: Single clock, flush clears contents
// Notes: Full and empty are exact; outputs read from flop storage
`timescale 1ns/1ps
`default_nettype none

module spi_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter PTR_W = 1
) (
  input wire clk,
  input wire nrst,
  input wire flush,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);

  localparam integer DEPTH_I = DEPTH;
  localparam integer LAST_I = DEPTH - 1;
  localparam [PTR_W:0] FULL = DEPTH_I[PTR_W:0];
  localparam [PTR_W-1:0] LAST = LAST_I[PTR_W-1:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wrPtr;
  reg [PTR_W-1:0] rdPtr;
  reg [PTR_W:0] count;
  wire push;
  wire pop;

  assign inReady = (count != FULL);
  assign outValid = (count != {(PTR_W+1){1'b0}});
  assign outData = mem[rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // ----------------------------------------
  // Pointers and count
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= {PTR_W{1'b0}};
      rdPtr <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
    end else if (flush) begin
      wrPtr <= {PTR_W{1'b0}};
      rdPtr <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == LAST) ? {PTR_W{1'b0}} : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == LAST) ? {PTR_W{1'b0}} : rdPtr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // spi_fifo

`default_nettype wire

/* File: hdl/spi_slave_master_enable_ctrl.v */
// Purpose: SPI unit working as slave or 3/4-pin master with enable modes
// Assumes: Pins arrive asynchronous; link clock far slower than clk
// Notes: MSB first; pins sampled through two flops, so master reads late
`timescale 1ns/1ps
`default_nettype none
`include "spi_map.vh"

module spi_slave_master_enable_ctrl #(
  parameter [7:0] HALF_PERIOD = `SPI_HALF_PERIOD
) (
  input wire clk,
  input wire nrst,
  input wire softResetBit,
  input wire masterMode,
  input wire fourPinMode,
  input wire clockPhaseSel,
  input wire clockPolaritySel,
  input wire enablePinModeSel,
  input wire [7:0] txData,
  input wire txValid,
  output wire txReady,
  output wire [7:0] rxData,
  output wire rxValid,
  input wire rxReady,
  output wire txFlag,
  output wire rxFlag,
  output reg abortPulse,
  output wire busy,
  input wire spiClkIn,
  output wire spiClkOut,
  output wire spiClkOe,
  input wire picoIn,
  output wire picoOut,
  output wire picoOe,
  input wire pociIn,
  output wire pociOut,
  output wire pociOe,
  input wire transferEnableIn,
  output reg transferEnableOut,
  output wire transferEnableOe
);

  localparam [7:0] HALF_LAST = HALF_PERIOD - 8'h01;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [3:0] syncA;
  reg [3:0] syncB;
  reg clkDly;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Enable starts inactive so no false selection follows reset
      syncA <= {~`SPI_ENABLE_ACTIVE, 3'h0};
      syncB <= {~`SPI_ENABLE_ACTIVE, 3'h0};
      clkDly <= 1'b0;
    end else begin
      syncA <= {transferEnableIn, pociIn, picoIn, spiClkIn};
      syncB <= syncA;
      clkDly <= syncB[0];
    end
  end

  wire clkLvl = syncB[0];
  wire picoS = syncB[1];
  wire pociS = syncB[2];
  wire enActive = (syncB[3] == `SPI_ENABLE_ACTIVE);
  wire idleLvl = clockPolaritySel;
  wire clkRise = clkLvl & ~clkDly;
  wire clkFall = ~clkLvl & clkDly;
  wire leadEdge = clockPolaritySel ? clkFall : clkRise;
  wire trailEdge = clockPolaritySel ? clkRise : clkFall;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire conflictMode = masterMode & fourPinMode & ~enablePinModeSel;
  wire enableOutMode = masterMode & fourPinMode & enablePinModeSel;
  wire slaveSel = ~fourPinMode | enActive;
  wire masterPermit = ~conflictMode | enActive;

  // ----------------------------------------
  // Buffers
  // ----------------------------------------
  reg [1:0] mState;
  reg [7:0] txShift;
  reg [7:0] rxShift;
  reg [7:0] rxByte;
  reg rxPush;
  reg [2:0] bitCnt;
  reg [3:0] halfCnt;
  reg [7:0] divCnt;
  reg spiClkDrv;
  reg slvArmed;
  reg slvLoaded;
  wire [7:0] txQData;
  wire txQValid;
  wire txInReady;
  wire rxInReady;

  // Writes refused while the conflict input blocks the master
  wire txAllow = ~softResetBit & masterPermit;
  assign txReady = txInReady & txAllow;
  assign txFlag = txInReady & ~softResetBit;
  assign rxFlag = rxValid;

  wire mStart = (mState == `SPI_M_IDLE) & masterMode & ~softResetBit &
                txQValid & rxInReady & masterPermit;
  wire slvGo = ~masterMode & ~softResetBit & slaveSel & slvArmed & ~slvLoaded;
  wire slvLoad = slvGo & (clockPhaseSel ? leadEdge : (clkLvl == idleLvl));
  wire txPop = (slvLoad & txQValid) | mStart;
  wire capBit = masterMode ? pociS : picoS;
  wire [7:0] capByte = {rxShift[6:0], capBit};

  spi_fifo #(
    .WIDTH(`SPI_BYTE_BITS),
    .DEPTH(`SPI_BUF_DEPTH),
    .PTR_W(`SPI_BUF_PTR_W)
  ) txFifo (
    .clk(clk),
    .nrst(nrst),
    .flush(softResetBit),
    .inData(txData),
    .inValid(txValid & txAllow),
    .inReady(txInReady),
    .outData(txQData),
    .outValid(txQValid),
    .outReady(txPop)
  );

  // Slave cannot stall the far master; a full receive side drops the byte
  spi_fifo #(
    .WIDTH(`SPI_BYTE_BITS),
    .DEPTH(`SPI_BUF_DEPTH),
    .PTR_W(`SPI_BUF_PTR_W)
  ) rxFifo (
    .clk(clk),
    .nrst(nrst),
    .flush(softResetBit),
    .inData(rxByte),
    .inValid(rxPush),
    .inReady(rxInReady),
    .outData(rxData),
    .outValid(rxValid),
    .outReady(rxReady)
  );

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mState <= `SPI_M_IDLE;
      txShift <= 8'h00;
      rxShift <= 8'h00;
      rxByte <= 8'h00;
      rxPush <= 1'b0;
      bitCnt <= 3'h0;
      halfCnt <= 4'h0;
      divCnt <= 8'h00;
      spiClkDrv <= 1'b0;
      slvArmed <= 1'b0;
      slvLoaded <= 1'b0;
      abortPulse <= 1'b0;
    end else begin
      rxPush <= 1'b0;
      abortPulse <= 1'b0;
      if (softResetBit) begin
        mState <= `SPI_M_IDLE;
        bitCnt <= 3'h0;
        slvArmed <= 1'b0;
        slvLoaded <= 1'b0;
        spiClkDrv <= idleLvl;
      end else if (masterMode) begin
        slvArmed <= 1'b0;
        slvLoaded <= 1'b0;
        case (mState)
          `SPI_M_IDLE: begin
            spiClkDrv <= idleLvl;
            if (mStart) begin
              txShift <= txQData;
              bitCnt <= 3'h0;
              halfCnt <= 4'h0;
              divCnt <= 8'h00;
              mState <= `SPI_M_RUN;
            end
          end
          `SPI_M_RUN: begin
            if (conflictMode & ~enActive) begin
              // Popped byte is dropped; software writes it again
              mState <= `SPI_M_IDLE;
              spiClkDrv <= idleLvl;
              abortPulse <= 1'b1;
            end else if (divCnt == HALF_LAST) begin
              divCnt <= 8'h00;
              halfCnt <= halfCnt + 4'h1;
              spiClkDrv <= ~spiClkDrv;
              if (halfCnt[0] == clockPhaseSel) begin
                rxShift <= capByte;
                bitCnt <= bitCnt + 3'h1;
                if (bitCnt == `SPI_LAST_BIT) begin
                  rxByte <= capByte;
                  rxPush <= 1'b1;
                end
              end else if (halfCnt != 4'h0) begin
                txShift <= {txShift[6:0], 1'b0};
              end
              if (halfCnt == `SPI_LAST_HALF) begin
                mState <= `SPI_M_GAP;
              end
            end else begin
              divCnt <= divCnt + 8'h01;
            end
          end
          `SPI_M_GAP: begin
            // One idle half period between bytes
            if (divCnt == HALF_LAST) begin
              divCnt <= 8'h00;
              mState <= `SPI_M_IDLE;
            end else begin
              divCnt <= divCnt + 8'h01;
            end
          end
          default: begin
            mState <= `SPI_M_IDLE;
          end
        endcase
      end else if (!slaveSel) begin
        bitCnt <= 3'h0;
        slvArmed <= 1'b0;
        slvLoaded <= 1'b0;
      end else if (!slvArmed) begin
        // Count edges only after the clock is seen at idle
        if (clkLvl == idleLvl) begin
          slvArmed <= 1'b1;
        end
      end else if (slvLoad) begin
        txShift <= txQValid ? txQData : `SPI_DUMMY_BYTE;
        slvLoaded <= 1'b1;
      end else if (leadEdge | trailEdge) begin
        if (leadEdge != clockPhaseSel) begin
          rxShift <= capByte;
          bitCnt <= bitCnt + 3'h1;
          if (bitCnt == `SPI_LAST_BIT) begin
            rxByte <= capByte;
            rxPush <= rxInReady;
            slvLoaded <= 1'b0;
          end
        end else if (slvLoaded) begin
          txShift <= {txShift[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // Enable output
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      transferEnableOut <= ~`SPI_ENABLE_ACTIVE;
    end else begin
      transferEnableOut <= (mState == `SPI_M_RUN) ? `SPI_ENABLE_ACTIVE :
                           ~`SPI_ENABLE_ACTIVE;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  assign transferEnableOe = enableOutMode & ~softResetBit;
  assign spiClkOut = spiClkDrv;
  assign spiClkOe = masterMode & ~softResetBit & masterPermit;
  assign picoOut = txShift[7];
  assign picoOe = masterMode & ~softResetBit & masterPermit;
  assign pociOut = txShift[7];
  assign pociOe = ~masterMode & ~softResetBit & slaveSel;
  assign busy = (mState != `SPI_M_IDLE) | slvLoaded;

endmodule // spi_slave_master_enable_ctrl

`default_nettype wire

/* File: dv/spi_far_model.sv */
// Purpose: Far-side model, SPI master toward a slave unit, slave toward a master unit
// Assumes: Link half period 40 ns; master-side tests use phase 0 and polarity 0
// Notes: A released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module spi_far_model (
  output logic sck,
  output logic mosi,
  output logic selN,
  input wire logic poci,
  input wire logic mClk,
  input wire logic mPico,
  output logic mPoci
);
  // ----------------------------------------
  // Link behaviour
  // ----------------------------------------
  logic [7:0] sreg = 8'h00;
  logic [7:0] cap = 8'h00;
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    selN = 1'b1;
  end
  assign mPoci = sreg[7];
  // Clock parked before soft reset release, else the slave misaligns
  task setIdle(input logic pol);
    sck = pol;
  endtask
  task xfer(input logic [7:0] d, input int n, input logic pha, input logic pol,
      output logic [7:0] got);
    // Pin changes kept off the clk edge
    #2;
    got = 8'h00;
    selN = 1'b0;
    #80;
    for (int i = 7; i > 7 - n; i--) begin
      if (pha) sck = ~pol;
      mosi = d[i];
      #40;
      sck = pha ? pol : ~pol;
      got[i] = poci;
      #40;
      sck = pol;
    end
    mosi = ~mosi;
    selN = 1'b1;
    #80;
  endtask
  task load(input logic [7:0] d);
    sreg = d;
    cap = 8'h00;
  endtask
  always @(posedge mClk) cap = {cap[6:0], mPico};
  always @(negedge mClk) sreg = {sreg[6:0], ~sreg[0]};
endmodule // spi_far_model
`default_nettype wire

/* File: dv/spi_slave_master_enable_ctrl_assertions.sv */
// Purpose: Port-level checks for the SPI unit
// Assumes: Mode inputs change only under soft reset
// Notes: Enable pin is active low
`timescale 1ns/1ps
`default_nettype none
module spi_slave_master_enable_ctrl_assertions #(
  parameter [7:0] HALF_PERIOD = 8'h04
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic softResetBit,
  input wire logic masterMode,
  input wire logic fourPinMode,
  input wire logic clockPolaritySel,
  input wire logic enablePinModeSel,
  input wire logic txReady,
  input wire logic rxValid,
  input wire logic txFlag,
  input wire logic rxFlag,
  input wire logic abortPulse,
  input wire logic busy,
  input wire logic spiClkOut,
  input wire logic transferEnableIn,
  input wire logic transferEnableOut,
  input wire logic transferEnableOe
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire cm = masterMode && fourPinMode && !enablePinModeSel;
  wire em = masterMode && fourPinMode && enablePinModeSel;
  a_idle_clk_level: assert property (
    $past(nrst) && $past(masterMode) && !busy && !$past(busy) && $stable(clockPolaritySel)
    |-> spiClkOut == clockPolaritySel) else $error("clock not at idle level");
  a_srst_no_tx: assert property (
    softResetBit |-> !txFlag && !txReady) else $error("tx open in soft reset");
  a_srst_held_idle: assert property (
    softResetBit ##1 softResetBit |-> !busy && !rxValid) else $error("busy in soft reset");
  a_rx_flag_level: assert property (
    rxFlag == rxValid) else $error("rx flag mismatch");
  a_abort_one_cycle: assert property (
    abortPulse |=> !abortPulse) else $error("abort too long");
  a_abort_cause: assert property (
    abortPulse |-> cm && $past(busy) && $past(transferEnableIn, 2)) else $error("bad abort");
  a_conflict_input: assert property (
    cm |-> !transferEnableOe) else $error("enable driven in conflict mode");
  a_enable_driven: assert property (
    em && !softResetBit |-> transferEnableOe) else $error("enable not driven");
  a_enable_in_frame: assert property (
    em && $rose(busy) |-> ##[0:2] !transferEnableOut) else $error("enable not asserted");
  a_blocked_load: assert property (
    (cm && transferEnableIn) [*4] |-> !txReady) else $error("write open while inactive");
endmodule // spi_slave_master_enable_ctrl_assertions
bind spi_slave_master_enable_ctrl spi_slave_master_enable_ctrl_assertions #(
  .HALF_PERIOD(HALF_PERIOD)) checks (.clk(clk), .nrst(nrst), .softResetBit(softResetBit),
  .masterMode(masterMode), .fourPinMode(fourPinMode), .clockPolaritySel(clockPolaritySel),
  .enablePinModeSel(enablePinModeSel), .txReady(txReady), .rxValid(rxValid),
  .txFlag(txFlag), .rxFlag(rxFlag), .abortPulse(abortPulse), .busy(busy),
  .spiClkOut(spiClkOut), .transferEnableIn(transferEnableIn),
  .transferEnableOut(transferEnableOut), .transferEnableOe(transferEnableOe));
`default_nettype wire

/* File: dv/test_spi_slave_master_enable_ctrl.sv */
// Purpose: Self-checking bench for the SPI unit
// Assumes: Far side is spi_far_model; default half period gives an 80 ns link
// Notes: Four-pin mode except one three-pin slave transfer; three-pin master is left untested
`timescale 1ns/1ps
`default_nettype none
module test_spi_slave_master_enable_ctrl;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic softResetBit = 1'b1;
  logic masterMode = 1'b0;
  logic fourPinMode = 1'b1;
  logic clockPhaseSel = 1'b0;
  logic clockPolaritySel = 1'b0;
  logic enablePinModeSel = 1'b0;
  logic [7:0] txData = 8'h00;
  logic txValid = 1'b0;
  logic rxReady = 1'b0;
  logic enN = 1'b0;
  logic [7:0] got;
  int i;
  int nFail = 0;
  int nChecks = 0;
  wire txReady, rxValid, txFlag, rxFlag, abortPulse, busy, spiClkOut, spiClkOe;
  wire picoOut, picoOe, pociOut, pociOe, transferEnableOut, transferEnableOe;
  wire sck, mosi, selN, mPoci;
  wire [7:0] rxData;
  // Pin level follows the unit's output enable, else the far model or enN drives it
  wire sckW = spiClkOe ? spiClkOut : sck;
  wire picoW = picoOe ? picoOut : mosi;
  wire pociW = pociOe ? pociOut : mPoci;
  wire enW = transferEnableOe ? transferEnableOut : (masterMode ? enN : selN);
  always #5 clk = ~clk;
  spi_slave_master_enable_ctrl uut (.clk(clk), .nrst(nrst), .softResetBit(softResetBit),
    .masterMode(masterMode), .fourPinMode(fourPinMode), .clockPhaseSel(clockPhaseSel),
    .clockPolaritySel(clockPolaritySel), .enablePinModeSel(enablePinModeSel),
    .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .txFlag(txFlag), .rxFlag(rxFlag),
    .abortPulse(abortPulse), .busy(busy), .spiClkIn(sckW), .spiClkOut(spiClkOut),
    .spiClkOe(spiClkOe), .picoIn(picoW), .picoOut(picoOut), .picoOe(picoOe),
    .pociIn(pociW), .pociOut(pociOut), .pociOe(pociOe), .transferEnableIn(enW),
    .transferEnableOut(transferEnableOut), .transferEnableOe(transferEnableOe));
  spi_far_model far (.sck(sck), .mosi(mosi), .selN(selN), .poci(pociW), .mClk(sckW),
    .mPico(picoW), .mPoci(mPoci));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task chk(input logic [7:0] g, input logic [7:0] e);
    nChecks++;
    if (g !== e) begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task endSim;
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task hang;
    nFail++;
    endSim;
  endtask
  // Modes change only under soft reset, so no half-set mode is seen
  task cfg(input logic m, input logic e, input logic pha, input logic pol);
    @(posedge clk);
    softResetBit <= 1'b1;
    masterMode <= m;
    enablePinModeSel <= e;
    clockPhaseSel <= pha;
    clockPolaritySel <= pol;
    far.setIdle(pol);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({6'h00, txFlag, rxFlag}, 8'h00);
    @(posedge clk);
    softResetBit <= 1'b0;
  endtask
  task wr(input logic [7:0] d);
    int j;
    @(posedge clk);
    txData <= d;
    txValid <= 1'b1;
    for (j = 0; j < 300; j++) begin
      @(negedge clk);
      if (txReady === 1'b1) break;
    end
    if (j == 300) hang;
    @(posedge clk);
    txValid <= 1'b0;
  endtask
  task pop(input logic [7:0] e);
    int j;
    for (j = 0; j < 300; j++) begin
      @(negedge clk);
      if (rxValid === 1'b1) break;
    end
    if (j == 300) hang;
    chk(rxData, e);
    @(posedge clk);
    rxReady <= 1'b1;
    @(posedge clk);
    rxReady <= 1'b0;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      cfg(1'b0, 1'b0, k[1], k[0]);
      wr(8'ha5 ^ k[7:0]);
      far.xfer(8'h3c + k[7:0], 8, k[1], k[0], got);
      chk(got, 8'ha5 ^ k[7:0]);
      pop(8'h3c + k[7:0]);
    end
    wr(8'h77);
    far.xfer(8'h11, 3, 1'b1, 1'b1, got);
    @(negedge clk);
    chk({6'h00, txFlag, rxFlag}, 8'h02);
    cfg(1'b0, 1'b0, 1'b1, 1'b1);
    wr(8'h96);
    far.xfer(8'h69, 8, 1'b1, 1'b1, got);
    chk(got, 8'h96);
    pop(8'h69);
    // Three-pin slave ignores the select line
    @(posedge clk);
    softResetBit <= 1'b1;
    fourPinMode <= 1'b0;
    cfg(1'b0, 1'b0, 1'b1, 1'b0);
    wr(8'h4b);
    far.xfer(8'hd2, 8, 1'b1, 1'b0, got);
    chk(got, 8'h4b);
    pop(8'hd2);
    @(negedge clk);
    chk({7'h00, pociOe}, 8'h01);
    @(posedge clk);
    softResetBit <= 1'b1;
    fourPinMode <= 1'b1;
    $display("test slave modes done");
    cfg(1'b1, 1'b1, 1'b0, 1'b0);
    far.load(8'h5a);
    wr(8'hc3);
    pop(8'h5a);
    chk(far.cap, 8'hc3);
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    enN <= 1'b1;
    repeat (6) @(negedge clk);
    chk({5'h00, spiClkOe, picoOe, txReady}, 8'h00);
    @(posedge clk);
    enN <= 1'b0;
    repeat (4) @(posedge clk);
    far.load(8'he7);
    wr(8'h81);
    repeat (20) @(posedge clk);
    enN <= 1'b1;
    for (i = 0; i < 30; i++) begin
      @(negedge clk);
      if (abortPulse === 1'b1) break;
    end
    chk({7'h00, i < 30}, 8'h01);
    if (i == 30) hang;
    chk({6'h00, txFlag, rxFlag}, 8'h02);
    @(posedge clk);
    enN <= 1'b0;
    repeat (4) @(posedge clk);
    far.load(8'he7);
    wr(8'h81);
    pop(8'he7);
    chk(far.cap, 8'h81);
    $display("test master modes done");
    endSim;
  end
endmodule // test_spi_slave_master_enable_ctrl
`default_nettype wire
